// File: timer16_pkg.sv
// Constants and types shared by the 16-bit timer capture and clock control block
// ==========================================================================
// Notes on behaviour
// (R1) Filter on: filtered capture input changes only after four equal raw samples.
// (R2) Filter on: capture events register four clock cycles later than filter off.
// (R3) Edge select zero triggers on falling edge, one on rising edge.
// (R4) Capture trigger copies counter into capture register and sets capture flag.
// (R5) Modes using capture register as top disconnect the capture input.
// (R6) Clock select 0 stops; 1 to 5 divide by 1, 8, 64, 256, 1024.
// (R7) Clock select 6 counts external falling edges, 7 external rising edges.
// (R8) Force bit in non-PWM modes applies immediate match per channel output mode.
// (R9) Forced match sets no flag and never clears the counter.
// (R10) Force bits act as one-cycle strobes and always read zero.
// (R11) Counter is readable and writable, byte pairs moved atomically via latch.
// (R12) One 8-bit high-byte latch is shared by all 16-bit registers.
// (R13) Counter write suppresses compare matches on the next timer tick.
// (R14) Capture source is capture pin or, optionally, the comparator output.
// (R15) Each 16-bit register: low byte at base, high byte at base plus one.
// (R16) Software should not modify a running counter or matches may be missed.
// (R17) Write high byte then low; low read loads high byte into latch.
package timer16_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_WAVE_CFG = 10'h080;
  localparam logic [IDX_W-1:0] IDX_CTRL_B = 10'h081;
  localparam logic [IDX_W-1:0] IDX_CTRL_C = 10'h082;
  localparam logic [IDX_W-1:0] IDX_CNT_LO = 10'h084;
  localparam logic [IDX_W-1:0] IDX_CNT_HI = 10'h085;
  localparam logic [IDX_W-1:0] IDX_CAP_LO = 10'h086;
  localparam logic [IDX_W-1:0] IDX_CAP_HI = 10'h087;
  localparam logic [IDX_W-1:0] IDX_CMPA_LO = 10'h088;
  localparam logic [IDX_W-1:0] IDX_CMPA_HI = 10'h089;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h08C;

  // ==========================================================================
  // Field positions
  localparam int CTRLB_FILTER_BIT = 7;
  localparam int CTRLB_EDGE_BIT = 6;
  localparam int CTRLB_WGM_MSB = 4;
  localparam int CTRLB_WGM_LSB = 3;
  localparam int CTRLB_CS_MSB = 2;
  localparam int CTRLC_FORCE_A_BIT = 7;
  localparam int CTRLC_FORCE_B_BIT = 6;
  localparam int WCFG_MODE_A_MSB = 7;
  localparam int WCFG_MODE_B_MSB = 5;
  localparam int WCFG_WGM_MSB = 1;
  localparam int STAT_CAPF_BIT = 0;
  localparam int STAT_MATCHA_BIT = 1;
  localparam int STAT_SRC_BIT = 2;
  localparam logic [7:0] CTRLB_WMASK = 8'hDF;
  localparam logic [7:0] WCFG_WMASK = 8'hF3;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ==========================================================================
  // Counting
  localparam int FILTER_LEN = 4;
  localparam int PRE_W = 10;
  localparam logic [PRE_W-1:0] DIV8_MASK = 10'h007;
  localparam logic [PRE_W-1:0] DIV64_MASK = 10'h03F;
  localparam logic [PRE_W-1:0] DIV256_MASK = 10'h0FF;
  localparam logic [PRE_W-1:0] DIV1024_MASK = 10'h3FF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] TOP_MAX = 16'hFFFF;

  // ==========================================================================
  // Waveform mode codes that matter here
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_CTC_CMPA = 4'h4;
  localparam logic [3:0] WGM_CTC_CAP = 4'hC;

  // ==========================================================================
  // Enumerations
  typedef enum logic [2:0] {
    CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
  } clock_select_t;

  typedef enum logic [1:0] {OM_OFF, OM_TOGGLE, OM_CLEAR, OM_SET} output_mode_t;

endpackage : timer16_pkg

// File: timer16_tick_gen.sv
// Prescaler and external edge detector that produce the timer tick
`timescale 1ns/100ps
`default_nettype none
module timer16_tick_gen
  import timer16_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Selection and external pin
  input wire clock_select_t clock_select,
  input wire logic ext_count_pin,
  // Tick
  output logic tick
);

  // ==========================================================================
  // Free-running prescaler; shared taps keep every divider phase-locked
  logic [PRE_W-1:0] pre_count;
  logic ext_prev;
  wire ext_fall = ext_prev & ~ext_count_pin;
  wire ext_rise = ~ext_prev & ext_count_pin;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_count <= '0;
      ext_prev <= 1'b0;
    end else begin
      pre_count <= pre_count + 1'b1;
      ext_prev <= ext_count_pin;
    end
  end

  // ==========================================================================
  // Tick selection
  always_comb begin
    unique case (clock_select)
      CS_STOP: tick = 1'b0; // see (R6)
      CS_DIV1: tick = 1'b1; // see (R6)
      CS_DIV8: tick = (pre_count & DIV8_MASK) == DIV8_MASK; // see (R6)
      CS_DIV64: tick = (pre_count & DIV64_MASK) == DIV64_MASK; // see (R6)
      CS_DIV256: tick = (pre_count & DIV256_MASK) == DIV256_MASK; // see (R6)
      CS_DIV1024: tick = (pre_count & DIV1024_MASK) == DIV1024_MASK; // see (R6)
      CS_EXT_FALL: tick = ext_fall; // see (R7)
      CS_EXT_RISE: tick = ext_rise; // see (R7)
    endcase
  end

endmodule : timer16_tick_gen
`default_nettype wire

// File: timer16_capture_clock_control.sv
// Top of the 16-bit timer: AXI4-Lite registers, capture, counter and forced compare
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module timer16_capture_clock_control
  import timer16_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Timer pins
  input wire logic capture_pin,
  input wire logic comparator_out,
  input wire logic ext_count_pin,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic capture_flag
);

  // ==========================================================================
  // Register state
  logic [7:0] wave_cfg;
  logic [7:0] ctrl_b;
  logic [15:0] counter_value;
  logic [15:0] capture_value;
  logic [15:0] compare_a_value;
  logic [7:0] high_latch;
  logic match_a_flag;
  logic capture_src_comp;
  logic block_match;
  logic [1:0] wave;

  // ==========================================================================
  // Write channel holding registers
  logic [ADDR_W-1:0] aw_hold;
  logic [DATA_W-1:0] w_hold;
  logic [3:0] wstrb_hold;

  wire do_write = ~awready & ~wready & ~bvalid;
  wire [IDX_W-1:0] wr_idx = aw_hold[ADDR_W-1:2];
  wire [7:0] wbyte = w_hold[7:0];
  wire wr_en = do_write & wstrb_hold[0];
  wire wr_wave_cfg = wr_en & (wr_idx == IDX_WAVE_CFG);
  wire wr_ctrl_b = wr_en & (wr_idx == IDX_CTRL_B);
  wire wr_ctrl_c = wr_en & (wr_idx == IDX_CTRL_C);
  wire wr_cnt_lo = wr_en & (wr_idx == IDX_CNT_LO);
  wire wr_cap_lo = wr_en & (wr_idx == IDX_CAP_LO);
  wire wr_cmpa_lo = wr_en & (wr_idx == IDX_CMPA_LO);
  wire wr_status = wr_en & (wr_idx == IDX_STATUS);
  // High-byte writes only fill the shared latch
  wire wr_any_hi = wr_en & ((wr_idx == IDX_CNT_HI) | (wr_idx == IDX_CAP_HI) |
                            (wr_idx == IDX_CMPA_HI)); // see (R15)
  wire wr_mapped = (wr_idx == IDX_WAVE_CFG) | (wr_idx == IDX_CTRL_B) |
                   (wr_idx == IDX_CTRL_C) | (wr_idx == IDX_CNT_LO) |
                   (wr_idx == IDX_CNT_HI) | (wr_idx == IDX_CAP_LO) |
                   (wr_idx == IDX_CAP_HI) | (wr_idx == IDX_CMPA_LO) |
                   (wr_idx == IDX_CMPA_HI) | (wr_idx == IDX_STATUS);

  // ==========================================================================
  // Read decode, taken at the address handshake
  wire rd_en = arvalid & arready;
  wire [IDX_W-1:0] rd_idx = araddr[ADDR_W-1:2];
  wire rd_cnt_lo = rd_en & (rd_idx == IDX_CNT_LO);
  wire rd_cap_lo = rd_en & (rd_idx == IDX_CAP_LO);
  wire rd_cmpa_lo = rd_en & (rd_idx == IDX_CMPA_LO);
  wire [7:0] status_byte = {5'h00, capture_src_comp, match_a_flag, capture_flag};
  logic [7:0] read_byte;
  logic rd_mapped;

  always_comb begin
    rd_mapped = 1'b1;
    unique case (rd_idx)
      IDX_WAVE_CFG: read_byte = wave_cfg;
      IDX_CTRL_B: read_byte = ctrl_b;
      IDX_CTRL_C: read_byte = BYTE_RESET; // see (R10)
      IDX_CNT_LO: read_byte = counter_value[7:0]; // see (R11)
      IDX_CAP_LO: read_byte = capture_value[7:0];
      IDX_CMPA_LO: read_byte = compare_a_value[7:0];
      IDX_CNT_HI, IDX_CAP_HI, IDX_CMPA_HI: read_byte = high_latch; // see (R12)
      IDX_STATUS: read_byte = status_byte;
      default: begin
        read_byte = BYTE_RESET;
        rd_mapped = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Mode decode
  wire [3:0] waveform_mode = {ctrl_b[CTRLB_WGM_MSB:CTRLB_WGM_LSB], wave_cfg[WCFG_WGM_MSB:0]};
  wire non_pwm = (waveform_mode == WGM_NORMAL) | (waveform_mode == WGM_CTC_CMPA) |
                 (waveform_mode == WGM_CTC_CAP);
  wire top_is_cmpa = (waveform_mode == WGM_CTC_CMPA) | (waveform_mode == 4'h9) |
                     (waveform_mode == 4'hB) | (waveform_mode == 4'hF);
  wire top_is_cap = (waveform_mode == WGM_CTC_CAP) | (waveform_mode == 4'h8) |
                    (waveform_mode == 4'hA) | (waveform_mode == 4'hE);
  wire top_8 = (waveform_mode == 4'h1) | (waveform_mode == 4'h5);
  wire top_9 = (waveform_mode == 4'h2) | (waveform_mode == 4'h6);
  wire top_10 = (waveform_mode == 4'h3) | (waveform_mode == 4'h7);
  wire [15:0] top_value = top_is_cmpa ? compare_a_value :
                          top_is_cap ? capture_value :
                          top_8 ? TOP_8BIT :
                          top_9 ? TOP_9BIT :
                          top_10 ? TOP_10BIT : TOP_MAX;

  // ==========================================================================
  // Timer tick
  logic tick;
  wire clock_select_t clock_select = clock_select_t'(ctrl_b[CTRLB_CS_MSB:0]);

  timer16_tick_gen u_tick_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .clock_select(clock_select),
    .ext_count_pin(ext_count_pin),
    .tick(tick)
  );

  // ==========================================================================
  // Capture input conditioning
  logic [FILTER_LEN-1:0] samples;
  logic filtered;
  logic unfiltered;
  logic sel_prev;
  wire raw_capture = capture_src_comp ? comparator_out : capture_pin; // see (R14)
  // Unfiltered path has one stage, filtered path four more
  wire all_high = &samples; // see (R1)
  wire all_low = ~|samples; // see (R1)
  wire selected = ctrl_b[CTRLB_FILTER_BIT] ? filtered : unfiltered; // see (R2)
  wire rise = selected & ~sel_prev;
  wire fall = ~selected & sel_prev;
  wire edge_hit = ctrl_b[CTRLB_EDGE_BIT] ? rise : fall; // see (R3)
  wire capture_event = edge_hit & ~top_is_cap; // see (R5)

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      samples <= '0;
      filtered <= 1'b0;
      unfiltered <= 1'b0;
      sel_prev <= 1'b0;
    end else begin
      samples <= {samples[FILTER_LEN-2:0], raw_capture};
      unfiltered <= raw_capture;
      if (all_high | all_low) begin
        filtered <= samples[FILTER_LEN-1]; // see (R1)
      end
      sel_prev <= selected;
    end
  end

  // ==========================================================================
  // Counter, matches and flags
  wire [15:0] commit_word = {high_latch, wbyte}; // see (R17)
  wire at_top = counter_value == top_value;
  // A counter write in flight also hides the match of this cycle
  wire match_a = tick & ~block_match & ~wr_cnt_lo &
                 (counter_value == compare_a_value); // see (R13)
  wire next_capture_flag = capture_event |
                           (capture_flag & ~(wr_status & wbyte[STAT_CAPF_BIT])); // see (R4)
  wire next_match_a_flag = match_a |
                           (match_a_flag & ~(wr_status & wbyte[STAT_MATCHA_BIT])); // see (R9)
  logic [7:0] next_high_latch;

  always_comb begin
    next_high_latch = high_latch;
    if (wr_any_hi) begin
      next_high_latch = wbyte; // see (R17)
    end else if (rd_cnt_lo) begin
      next_high_latch = counter_value[15:8]; // see (R17)
    end else if (rd_cap_lo) begin
      next_high_latch = capture_value[15:8];
    end else if (rd_cmpa_lo) begin
      next_high_latch = compare_a_value[15:8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_value <= WORD_RESET;
      block_match <= 1'b0;
    end else if (wr_cnt_lo) begin
      counter_value <= commit_word; // see (R11)
      block_match <= 1'b1; // see (R13)
    end else if (tick) begin
      // Only the counter reaching top wraps, even on a blocked tick; a forced match never does
      counter_value <= at_top ? WORD_RESET : counter_value + 16'h0001; // see (R9)
      block_match <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_value <= WORD_RESET;
    end else if (capture_event) begin
      capture_value <= counter_value; // see (R4)
    end else if (wr_cap_lo) begin
      capture_value <= commit_word;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_cfg <= BYTE_RESET;
      ctrl_b <= BYTE_RESET;
      compare_a_value <= WORD_RESET;
      high_latch <= BYTE_RESET;
      capture_flag <= 1'b0;
      match_a_flag <= 1'b0;
      capture_src_comp <= 1'b0;
    end else begin
      if (wr_wave_cfg) begin
        wave_cfg <= wbyte & WCFG_WMASK;
      end
      if (wr_ctrl_b) begin
        ctrl_b <= wbyte & CTRLB_WMASK;
      end
      if (wr_cmpa_lo) begin
        compare_a_value <= commit_word;
      end
      if (wr_status) begin
        capture_src_comp <= wbyte[STAT_SRC_BIT];
      end
      high_latch <= next_high_latch; // see (R12)
      capture_flag <= next_capture_flag;
      match_a_flag <= next_match_a_flag;
    end
  end

  // ==========================================================================
  // Waveform outputs per channel; channel B has no comparator of its own here
  wire [1:0] force_bit = {wbyte[CTRLC_FORCE_B_BIT], wbyte[CTRLC_FORCE_A_BIT]};
  wire [1:0] real_match = {1'b0, match_a};
  wire [3:0] mode_bits = {wave_cfg[WCFG_MODE_B_MSB -: 2], wave_cfg[WCFG_MODE_A_MSB -: 2]};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_channel
      wire output_mode_t output_mode = output_mode_t'(mode_bits[2*ch +: 2]);
      // The strobe lives one cycle; nothing of it is stored
      wire force_strobe = wr_ctrl_c & force_bit[ch] & non_pwm; // see (R8) (R10)
      wire apply = force_strobe | (real_match[ch] & non_pwm);
      logic next_wave;

      always_comb begin
        next_wave = wave[ch];
        if (apply) begin
          unique case (output_mode)
            OM_OFF: next_wave = wave[ch];
            OM_TOGGLE: next_wave = ~wave[ch]; // see (R8)
            OM_CLEAR: next_wave = 1'b0; // see (R8)
            OM_SET: next_wave = 1'b1; // see (R8)
          endcase
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          wave[ch] <= 1'b0;
        end else begin
          wave[ch] <= next_wave;
        end
      end
    end
  endgenerate

  assign wave_out_a = wave[0];
  assign wave_out_b = wave[1];

  // ==========================================================================
  // AXI4-Lite handshakes; ready low means the slot holds a beat
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      aw_hold <= '0;
      w_hold <= '0;
      wstrb_hold <= 4'h0;
    end else begin
      if (awvalid & awready) begin
        aw_hold <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid & wready) begin
        w_hold <= wdata;
        wstrb_hold <= wstrb;
        wready <= 1'b0;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid & bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (rd_en) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, read_byte};
      rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid & rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule : timer16_capture_clock_control
`default_nettype wire

// File: timer16_monitor.sv
// Bus and pin checker for the 16-bit timer top
`timescale 1ns/100ps
`default_nettype none
module timer16_monitor
  import timer16_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // Pins
  input wire logic wave_out_b,
  input wire logic capture_flag
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // Write steps
  sequence s_write_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_write_done;
    bvalid && bready;
  endsequence
  property p_write_answer;
    s_write_taken |=> !awready && !wready ##1 bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered");
  property p_b_stands;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_stands: assert property (p_b_stands) else $error("write response dropped");
  property p_b_release;
    s_write_done |=> !bvalid && awready && wready;
  endproperty
  a_b_release: assert property (p_b_release) else $error("write slot not freed");
  // ==========
  // Reads
  property p_read_answer;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_r_stands;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_stands: assert property (p_r_stands) else $error("read data dropped");
  property p_byte_lane;
    rvalid |-> rdata[31:8] == '0;
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("upper read bits set");
  // ==========
  // Wave B moves and the capture flag falls only on a register write
  property p_force_b;
    $changed(wave_out_b) && $past(aresetn) |-> $rose(bvalid);
  endproperty
  a_force_b: assert property (p_force_b) else $error("wave b moved without write");
  property p_flag_clear;
    $fell(capture_flag) && $past(aresetn) |-> $rose(bvalid);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag fell without write");
endmodule : timer16_monitor
bind timer16_capture_clock_control timer16_monitor timer16_monitor_inst (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .arvalid, .arready, .rdata, .rvalid, .rready, .wave_out_b, .capture_flag
);
`default_nettype wire

// File: timer16_pins.sv
// Model of the capture, comparator and external count sources
`timescale 1ns/100ps
`default_nettype none
module timer16_pins (
  // Clock
  input wire logic aclk,
  // Pins
  output logic capture_pin,
  output logic comparator_out,
  output logic ext_count_pin
);
  initial begin
    capture_pin = 1'b0;
    comparator_out = 1'b0;
    ext_count_pin = 1'b0;
  end
  // Levels move just after an edge so the block samples them cleanly
  task automatic set_cap(input logic v);
    @(posedge aclk);
    capture_pin <= v;
  endtask : set_cap
  task automatic set_cmp(input logic v);
    @(posedge aclk);
    comparator_out <= v;
  endtask : set_cmp
  // Each pulse has one edge of each kind, held past the synchroniser
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge aclk);
      ext_count_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_count_pin <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask : ext_pulses
endmodule : timer16_pins
`default_nettype wire

// File: tb.sv
// Register-level testbench of the 16-bit timer
`timescale 1ns/100ps
`default_nettype none
module tb
  import timer16_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, wave_out_a, wave_out_b, capture_flag;
  logic [1:0] bresp, rresp;
  logic capture_pin, comparator_out, ext_count_pin;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int div[6] = '{0, 1, 8, 64, 256, 1024};
  timer16_capture_clock_control timer16_capture_clock_control_inst (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .capture_pin, .comparator_out, .ext_count_pin, .wave_out_a, .wave_out_b,
    .capture_flag
  );
  timer16_pins timer16_pins_inst (.aclk, .capture_pin, .comparator_out, .ext_count_pin);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // ==========
  // Checks and verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Prescaler phase is free running, so a count may be off by one
  task automatic chk_near(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp && got !== exp + 16'h0001 && got !== exp - 16'h0001) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: count %h near %h", $time, got, exp);
    end
  endtask : chk_near
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // ==========
  // Bus master
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {~d, d, ~d, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    repeat (2) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(16'(bresp), 16'(RESP_OKAY));
  endtask : wr
  task automatic rd(input logic [9:0] idx, output logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk(16'(r), 16'(RESP_OKAY));
    chk(16'(d), 16'(exp));
  endtask : rdc
  // ==========
  // Tests
  initial begin
    logic [7:0] lo, hi;
    logic [1:0] r;
    logic [15:0] c0, c1;
    int t0, t1;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (div[i]) rdc(IDX_CTRL_B + 10'(i) + 10'(i > 1), 8'h00);
    rd(10'h383, lo, r);
    chk(16'(r), 16'(RESP_SLVERR));
    wr(IDX_CTRL_B, 8'hFF);
    rdc(IDX_CTRL_B, 8'hDF);
    wr(IDX_CTRL_B, 8'h00);
    wstrb <= 4'h0;
    wr(IDX_CTRL_B, 8'h5A);
    wstrb <= 4'hF;
    rdc(IDX_CTRL_B, 8'h00);
    wr(IDX_CMPA_HI, 8'h12);
    wr(IDX_CMPA_LO, 8'h34);
    rdc(IDX_CMPA_LO, 8'h34);
    rdc(IDX_CAP_HI, 8'h12);
    rdc(IDX_CMPA_HI, 8'h12);
    $display("registers done");
    for (int cs = 0; cs < 8; cs++) begin
      wr(IDX_CNT_HI, 8'h00);
      wr(IDX_CNT_LO, 8'h00);
      wr(IDX_CTRL_B, 8'(cs));
      t0 = cyc;
      if (cs > 5) timer16_pins_inst.ext_pulses(5);
      else repeat (3072) @(posedge aclk);
      wr(IDX_CTRL_B, 8'h00);
      t1 = cyc;
      rd(IDX_CNT_LO, lo, r);
      rd(IDX_CNT_HI, hi, r);
      c0 = (cs == 0) ? 16'h0000 : (cs > 5) ? 16'h0005 : 16'((t1 - t0) / div[cs]);
      chk_near({hi, lo}, c0);
    end
    $display("clock select done");
    for (int f = 0; f < 2; f++) begin
      wr(IDX_CTRL_B, f ? 8'hC0 : 8'h40);
      wr(IDX_STATUS, 8'h01);
      wr(IDX_CNT_HI, 8'h00);
      wr(IDX_CNT_LO, 8'h00);
      wr(IDX_CTRL_B, f ? 8'hC1 : 8'h41);
      repeat (10) @(posedge aclk);
      timer16_pins_inst.set_cap(1'b1);
      repeat (12) @(posedge aclk);
      chk(16'(capture_flag), 16'h0001);
      wr(IDX_CTRL_B, f ? 8'hC0 : 8'h40);
      rd(IDX_CAP_LO, lo, r);
      rd(IDX_CAP_HI, hi, r);
      if (f) c1 = {hi, lo};
      else c0 = {hi, lo};
      wr(IDX_STATUS, 8'h01);
      timer16_pins_inst.set_cap(1'b0);
      repeat (12) @(posedge aclk);
      chk(16'(capture_flag), 16'h0000);
    end
    chk(c1 - c0, 16'h0004);
    wr(IDX_CTRL_B, 8'h59);
    timer16_pins_inst.set_cap(1'b1);
    repeat (12) @(posedge aclk);
    chk(16'(capture_flag), 16'h0000);
    wr(IDX_CTRL_B, 8'h40);
    timer16_pins_inst.set_cap(1'b0);
    wr(IDX_STATUS, 8'h05);
    timer16_pins_inst.set_cmp(1'b1);
    repeat (12) @(posedge aclk);
    rdc(IDX_STATUS, 8'h05);
    wr(IDX_STATUS, 8'h01);
    rdc(IDX_STATUS, 8'h00);
    $display("capture done");
    wr(IDX_CTRL_B, 8'h08);
    wr(IDX_WAVE_CFG, 8'h70);
    wr(IDX_CNT_HI, 8'h00);
    wr(IDX_CNT_LO, 8'h55);
    wr(IDX_CMPA_LO, 8'h55);
    wr(IDX_CTRL_C, 8'hC0);
    chk({wave_out_a, wave_out_b}, 16'h0003);
    rdc(IDX_CTRL_C, 8'h00);
    rdc(IDX_STATUS, 8'h00);
    rdc(IDX_CNT_LO, 8'h55);
    wr(IDX_CTRL_C, 8'h80);
    chk({wave_out_a, wave_out_b}, 16'h0001);
    wr(IDX_WAVE_CFG, 8'h71);
    wr(IDX_CTRL_C, 8'h80);
    chk({wave_out_a, wave_out_b}, 16'h0001);
    $display("force done");
    wr(IDX_WAVE_CFG, 8'h00);
    wr(IDX_CTRL_B, 8'h07);
    wr(IDX_CMPA_HI, 8'h00);
    wr(IDX_CMPA_LO, 8'h06);
    wr(IDX_CNT_HI, 8'h00);
    wr(IDX_CNT_LO, 8'h06);
    wr(IDX_STATUS, 8'h02);
    timer16_pins_inst.ext_pulses(1);
    rdc(IDX_STATUS, 8'h00);
    wr(IDX_CNT_HI, 8'h00);
    wr(IDX_CNT_LO, 8'h05);
    timer16_pins_inst.ext_pulses(2);
    rdc(IDX_STATUS, 8'h02);
    rdc(IDX_CNT_LO, 8'h07);
    $display("match block done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
